// file: inc/stlf_pkg.sv
// package: sizes, alignment and carrier types for store-to-load forwarding
package stlf_pkg;
    localparam int ADDR_W        = 48;
    localparam int DATA_W        = 128;
    localparam int SB_DEPTH      = 8;
    localparam int MISALIGN_PEN  = 1;
    localparam int DWORD_BYTES   = 4;
    localparam int UPPER_QW_OFS  = 8;
    localparam int AM_BIT        = 18;
    localparam int CTRL_W        = 32;

    // operand sizes in bytes, encoded
    typedef enum logic [2:0] {
        SZ_BYTE,
        SZ_WORD,
        SZ_DWORD,
        SZ_QWORD,
        SZ_TBYTE,
        SZ_DQWORD
    } stlf_size_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        stlf_size_t        size;
        logic [3:0]        tag;
    } stlf_ld_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        stlf_size_t        size;
        logic [DATA_W-1:0] data;
    } stlf_st_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [3:0]        tag;
        logic              fwd;
        logic              alignFault;
    } stlf_ld_rsp_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        stlf_size_t        size;
        logic [DATA_W-1:0] data;
    } stlf_dc_wr_t;
endpackage

// file: hw/stlf_match.sv
// per-entry forwarding decision for one buffered store against one load
`timescale 1ns/1ps
`default_nettype none
module stlf_match
    import stlf_pkg::*;
(
    input  wire logic [ADDR_W-1:0] ldAddr,    // load start address
    input  wire stlf_size_t        ldSize,    // load size
    input  wire logic [ADDR_W-1:0] stAddr,    // store start address
    input  wire stlf_size_t        stSize,    // store size
    input  wire logic              stMixed,   // entry hit by a sibling sub-dword store
    output logic                   overlap,   // byte ranges intersect
    output logic                   allow,     // forwarding permitted
    output logic                   upperHalf  // forward from upper quadword
);
    function automatic logic [4:0] nbytes(input stlf_size_t s);
        case (s)
            SZ_BYTE:  nbytes = 5'h01;
            SZ_WORD:  nbytes = 5'h02;
            SZ_DWORD: nbytes = 5'h04;
            SZ_QWORD: nbytes = 5'h08;
            SZ_TBYTE: nbytes = 5'h0a;
            default:  nbytes = 5'h10;
        endcase
    endfunction

    function automatic logic [4:0] algn(input stlf_size_t s);
        case (s)
            SZ_TBYTE: algn = 5'h08;
            default:  algn = nbytes(s);
        endcase
    endfunction

    logic [ADDR_W-1:0] ldEnd;
    logic [ADDR_W-1:0] stEnd;
    logic              aligned;
    logic              sizeOk;
    logic              sameStart;
    logic              subDword;
    always_comb begin
        ldEnd     = ldAddr + ADDR_W'(nbytes(ldSize));
        stEnd     = stAddr + ADDR_W'(nbytes(stSize));
        overlap   = (ldAddr < stEnd) && (stAddr < ldEnd);
        aligned   = ((ldAddr[4:0] & (algn(ldSize) - 5'h01)) == 5'h00)
                 && ((stAddr[4:0] & (algn(stSize) - 5'h01)) == 5'h00);
        sizeOk    = nbytes(ldSize) <= nbytes(stSize);
        sameStart = ldAddr == stAddr;
        subDword  = ldSize inside {SZ_BYTE, SZ_WORD};
        upperHalf = (stSize == SZ_DQWORD) && (ldAddr == stAddr + ADDR_W'(UPPER_QW_OFS))
                 && (nbytes(ldSize) <= 5'h08);
        allow     = aligned && ((sameStart && sizeOk) || upperHalf)
                 && !(subDword && stMixed);
    end
endmodule
`default_nettype wire

// file: hw/stlf_unit.sv
// store buffer with store-to-load forwarding and retirement-ordered drain
//
// Behaviour
// - permitted loads take data straight from the youngest overlapping older store entry.
// - refuse forwarding when load and store start addresses differ, except a load at the upper quadword of a 128-bit store.
// - refuse forwarding when the load is wider than the store.
// - refuse forwarding when load or store is misaligned.
// - separate high and low sub-dword stores in a dword block sub-dword load forwarding.
// - aligned 128-bit store forwards to a load of 64 bits or less at its upper quadword.
// - wider store forwards to narrower load at the same aligned start.
// - a store entry writes the cache only after the reorder buffer retires it.
// - a refused load waits until the conflicting store has written the cache or a younger overlapping store permits forwarding.
// - misaligned loads cost at least one extra pipeline cycle.
// - alignment is judged by divisibility per size, ten-byte objects by eight.
// - with the alignment-mask bit set and checking enabled by mode, unaligned loads raise an alignment fault.
`timescale 1ns/1ps
`default_nettype none
module stlf_unit
    import stlf_pkg::*;
#(
    parameter int DEPTH = SB_DEPTH
)(
    input  wire logic              core_clk,    // core clock
    input  wire logic              rst,         // synchronous reset, active high
    input  wire logic [CTRL_W-1:0] ctrlReg0,    // control_register_zero image
    input  wire logic              alignChkEn,  // alignment checking enabled by mode
    input  wire logic              stValid,     // store enters buffer
    input  wire stlf_st_req_t      stReq,       // store address, size, data
    output logic                   stReady,     // buffer can take a store
    input  wire logic              retireSt,    // reorder buffer retires oldest store
    input  wire logic              ldValid,     // load request
    input  wire stlf_ld_req_t      ldReq,       // load address, size, tag
    output logic                   ldReady,     // load port free
    output logic                   dcRdEn,      // data cache read strobe
    output logic [ADDR_W-1:0]      dcRdAddr,    // data cache read address
    input  wire logic [DATA_W-1:0] dcRdData,    // cache data, sampled at the edge that ends the strobe cycle
    output logic                   dcWrEn,      // data cache write strobe
    output stlf_dc_wr_t            dcWr,        // data cache write
    output logic                   ldRspValid,  // load answer strobe
    output stlf_ld_rsp_t           ldRsp        // load answer
);
    if (DEPTH < 2 || DEPTH > 16 || (DEPTH & (DEPTH - 1)) != 0) begin : gBadDepth
        $error("DEPTH must be a power of two from 2 to 16");
    end

    localparam int PW = $clog2(DEPTH);

    // ----------------------------------------------------------------
    // store buffer
    // ----------------------------------------------------------------
    stlf_st_req_t sb_q [DEPTH];
    logic [DEPTH-1:0] sbValid_q;
    logic [DEPTH-1:0] sbRetired_q;
    logic [DEPTH-1:0] sbMixed_q;
    logic [PW-1:0]    head_q;
    logic [PW-1:0]    tail_q;
    logic [PW:0]      count_q;
    logic [PW:0]      retCnt_q;

    function automatic logic subDw(input stlf_size_t s);
        subDw = (s == SZ_BYTE) || (s == SZ_WORD);
    endfunction

    function automatic logic misal(input logic [ADDR_W-1:0] a, input stlf_size_t s);
        case (s)
            SZ_BYTE:   misal = 1'b0;
            SZ_WORD:   misal = a[0] != 1'b0;
            SZ_DWORD:  misal = a[1:0] != 2'h0;
            SZ_QWORD:  misal = a[2:0] != 3'h0;
            SZ_TBYTE:  misal = a[2:0] != 3'h0;
            default:   misal = a[3:0] != 4'h0;
        endcase
    endfunction

    logic push;
    logic drain;
    always_comb begin
        push  = stValid && stReady;
        drain = dcWrEn;
    end

    // sibling sub-dword stores to other bytes of the same dword
    logic [DEPTH-1:0] sibling;
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            sibling[i] = sbValid_q[i] && subDw(sb_q[i].size) && subDw(stReq.size)
                      && (sb_q[i].addr[ADDR_W-1:2] == stReq.addr[ADDR_W-1:2])
                      && (sb_q[i].addr != stReq.addr);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sbValid_q <= '0;
            sbMixed_q <= '0;
            tail_q    <= '0;
        end else begin
            if (push) begin
                sb_q[tail_q]      <= stReq;
                sbValid_q[tail_q] <= 1'b1;
                sbMixed_q[tail_q] <= |sibling;
                tail_q            <= tail_q + PW'(1);
            end
            if (push) begin
                sbMixed_q <= sbMixed_q | sibling;
                sbMixed_q[tail_q] <= |sibling;
            end
            if (drain) begin
                sbValid_q[head_q] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // retirement and drain
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sbRetired_q <= '0;
            retCnt_q    <= '0;
            head_q      <= '0;
            count_q     <= '0;
        end else begin
            if (retireSt && retCnt_q < count_q) begin
                sbRetired_q[PW'(head_q + PW'(retCnt_q))] <= 1'b1;
            end
            if (drain) begin
                sbRetired_q[head_q] <= 1'b0;
                head_q              <= head_q + PW'(1);
            end
            retCnt_q <= retCnt_q + (PW+1)'(retireSt && retCnt_q < count_q) - (PW+1)'(drain);
            count_q  <= count_q + (PW+1)'(push) - (PW+1)'(drain);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dcWrEn  <= 1'b0;
            dcWr    <= '0;
            stReady <= 1'b0;
        end else begin
            dcWrEn  <= 1'b0;
            if (!dcWrEn && sbValid_q[head_q] && sbRetired_q[head_q]) begin
                dcWrEn <= 1'b1;
                dcWr   <= sb_q[head_q];
            end
            stReady <= (count_q + (PW+1)'(push)) < (PW+1)'(DEPTH);
        end
    end

    // ----------------------------------------------------------------
    // forwarding search
    // ----------------------------------------------------------------
    stlf_ld_req_t ld_q;
    logic [DEPTH-1:0] ovl;
    logic [DEPTH-1:0] alw;
    logic [DEPTH-1:0] upr;

    for (genvar g = 0; g < DEPTH; g++) begin : gMatch
        stlf_match uMatch (
            .ldAddr    (ld_q.addr),
            .ldSize    (ld_q.size),
            .stAddr    (sb_q[g].addr),
            .stSize    (sb_q[g].size),
            .stMixed   (sbMixed_q[g]),
            .overlap   (ovl[g]),
            .allow     (alw[g]),
            .upperHalf (upr[g])
        );
    end

    // youngest overlapping entry wins
    logic            hit;
    logic            hitOk;
    logic [PW-1:0]   hitIdx;
    always_comb begin
        hit    = 1'b0;
        hitOk  = 1'b0;
        hitIdx = '0;
        for (int k = 0; k < DEPTH; k++) begin
            if (sbValid_q[PW'(head_q + PW'(k))] && ovl[PW'(head_q + PW'(k))]) begin
                hit    = 1'b1;
                hitIdx = PW'(head_q + PW'(k));
                hitOk  = alw[PW'(head_q + PW'(k))];
            end
        end
    end

    // ----------------------------------------------------------------
    // load pipeline
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {LD_IDLE, LD_PEN, LD_LOOK, LD_WAIT, LD_READ} stlf_ld_st_t;
    stlf_ld_st_t ldSt_q;
    logic        ldMis_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ldSt_q     <= LD_IDLE;
            ld_q       <= '0;
            ldMis_q    <= 1'b0;
            ldReady    <= 1'b0;
            ldRspValid <= 1'b0;
            ldRsp      <= '0;
            dcRdEn     <= 1'b0;
            dcRdAddr   <= '0;
        end else begin
            ldRspValid <= 1'b0;
            dcRdEn     <= 1'b0;
            case (ldSt_q)
                LD_IDLE: begin
                    ldReady <= 1'b1;
                    if (ldValid && ldReady) begin
                        ldReady <= 1'b0;
                        ld_q    <= ldReq;
                        ldMis_q <= misal(ldReq.addr, ldReq.size);
                        ldSt_q  <= misal(ldReq.addr, ldReq.size) ? LD_PEN : LD_LOOK;
                    end
                end
                LD_PEN: begin
                    ldSt_q <= LD_LOOK;
                end
                LD_LOOK: begin
                    if (ldMis_q && alignChkEn && ctrlReg0[AM_BIT]) begin
                        ldRspValid       <= 1'b1;
                        ldRsp            <= '0;
                        ldRsp.tag        <= ld_q.tag;
                        ldRsp.alignFault <= 1'b1;
                        ldSt_q           <= LD_IDLE;
                    end else if (hit && hitOk) begin
                        ldRspValid <= 1'b1;
                        ldRsp.tag  <= ld_q.tag;
                        ldRsp.fwd  <= 1'b1;
                        ldRsp.alignFault <= 1'b0;
                        ldRsp.data <= upr[hitIdx] ? (sb_q[hitIdx].data >> 64) : sb_q[hitIdx].data;
                        ldSt_q     <= LD_IDLE;
                    end else if (hit) begin
                        ldSt_q <= LD_WAIT;
                    end else begin
                        dcRdEn   <= 1'b1;
                        dcRdAddr <= ld_q.addr;
                        ldSt_q   <= LD_READ;
                    end
                end
                LD_WAIT: begin
                    if (!hit) begin
                        ldSt_q <= LD_LOOK;
                    end else if (hitOk) begin
                        ldSt_q <= LD_LOOK;
                    end
                end
                LD_READ: begin
                    ldRspValid       <= 1'b1;
                    ldRsp.data       <= dcRdData;
                    ldRsp.tag        <= ld_q.tag;
                    ldRsp.fwd        <= 1'b0;
                    ldRsp.alignFault <= 1'b0;
                    ldSt_q           <= LD_IDLE;
                end
                default: ldSt_q <= LD_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: test/stlf_unit_properties.sv
// checker: port timing properties of the forwarding unit
`timescale 1ns/1ps
`default_nettype none
module stlf_unit_props
    import stlf_pkg::*;
(
    input wire logic              core_clk,   // core clock
    input wire logic              rst,        // sync reset
    input wire logic [CTRL_W-1:0] ctrlReg0,   // control image
    input wire logic              alignChkEn, // mode check enable
    input wire logic              retireSt,   // retire pulse
    input wire logic              ldValid,    // load request
    input wire stlf_ld_req_t      ldReq,      // load fields
    input wire logic              ldReady,    // load port free
    input wire logic              dcRdEn,     // cache read
    input wire logic              dcWrEn,     // cache write
    input wire logic              ldRspValid, // answer strobe
    input wire stlf_ld_rsp_t      ldRsp       // answer
);
    // ------------------------------
    // helper logic
    // ------------------------------
    function automatic logic mis(logic [3:0] a, stlf_size_t s);
        case (s)
            SZ_WORD: return a[0];
            SZ_DWORD: return |a[1:0];
            SZ_QWORD, SZ_TBYTE: return |a[2:0];
            SZ_DQWORD: return |a;
            default: return 1'b0;
        endcase
    endfunction
    wire logic takeLd = ldValid && ldReady;
    wire logic takeMis = takeLd && mis(ldReq.addr[3:0], ldReq.size);
    logic [4:0] retQ;
    logic       misQ;
    always_ff @(posedge core_clk) begin
        if (rst) retQ <= 5'h0;
        else retQ <= retQ + 5'(retireSt) - 5'(dcWrEn);
    end
    always_ff @(posedge core_clk) begin
        if (rst) misQ <= 1'b0;
        else if (takeLd) misQ <= takeMis;
    end
    // ------------------------------
    // properties
    // ------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    drain_retired_a: assert property (dcWrEn |-> retQ != 5'h0) else $error("drain without retire");
    drain_gap_a: assert property (dcWrEn |=> !dcWrEn) else $error("back to back drain");
    one_load_a: assert property (takeLd |=> !ldReady) else $error("second load accepted");
    cache_rsp_a: assert property (dcRdEn |=> ldRspValid && !ldRsp.fwd) else $error("no answer after read");
    fault_cause_a: assert property (ldRspValid && ldRsp.alignFault |-> misQ && ctrlReg0[AM_BIT] && alignChkEn)
        else $error("fault without cause");
    mis_penalty_a: assert property (takeMis |=> !ldRspValid [*2]) else $error("misaligned answer too early");
    mis_nofwd_a: assert property (ldRspValid && misQ |-> !ldRsp.fwd) else $error("misaligned load forwarded");
    fwd_timing_a: assert property (ldRspValid && ldRsp.fwd |-> $past(takeLd, 2)) else $error("late forward");
    reset_quiet_a: assert property (disable iff (1'b0) rst |=> !ldRspValid && !dcWrEn && !dcRdEn)
        else $error("output active in reset");
    cover property (ldRspValid && ldRsp.fwd);
    cover property (ldRspValid && ldRsp.alignFault);
    cover property (dcRdEn ##1 ldRspValid);
endmodule
bind stlf_unit stlf_unit_props u_props (.core_clk(core_clk), .rst(rst), .ctrlReg0(ctrlReg0),
    .alignChkEn(alignChkEn), .retireSt(retireSt), .ldValid(ldValid), .ldReq(ldReq), .ldReady(ldReady),
    .dcRdEn(dcRdEn), .dcWrEn(dcWrEn), .ldRspValid(ldRspValid), .ldRsp(ldRsp));
`default_nettype wire

// file: test/stlf_dcache_model.sv
// partner model: byte-addressed data cache behind the forwarding unit
`timescale 1ns/1ps
`default_nettype none
module stlf_dcache_model
    import stlf_pkg::*;
(
    input  wire logic              core_clk, // core clock
    input  wire logic              dcRdEn,   // read strobe
    input  wire logic [ADDR_W-1:0] dcRdAddr, // read address
    input  wire logic              dcWrEn,   // write strobe
    input  wire stlf_dc_wr_t       dcWr,     // write request
    output logic [DATA_W-1:0]      dcRdData  // read data, settled within the strobe cycle
);
    logic [7:0] mem [logic [ADDR_W-1:0]];
    int         nb;
    initial dcRdData = '0;
    always @(posedge core_clk) begin
        if (dcWrEn) begin
            nb = (dcWr.size == SZ_DQWORD) ? 16 : (dcWr.size == SZ_TBYTE) ? 10 : 1 << dcWr.size;
            for (int i = 0; i < nb; i++) mem[dcWr.addr + i] = dcWr.data[i*8 +: 8];
        end
    end
    // unit samples read data at the edge that ends its strobe cycle, so answer mid-cycle
    // idle data toggles so a stray sample never matches
    always @(negedge core_clk) begin
        for (int i = 0; i < 16; i++)
            dcRdData[i*8 +: 8] <= !dcRdEn ? ~dcRdData[i*8 +: 8] :
                mem.exists(dcRdAddr + i) ? mem[dcRdAddr + i] : 8'h5a ^ 8'(i);
    end
endmodule
`default_nettype wire

// file: test/store_to_load_forwarding_tb_top.sv
// testbench: forwarding, refusal, drain and fault scenarios
`timescale 1ns/1ps
`default_nettype none
module store_to_load_forwarding_tb_top
    import stlf_pkg::*;
;
    localparam logic [DATA_W-1:0] D1 = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
    localparam logic [DATA_W-1:0] D2 = 128'hc3a5_1122_3344_5566_8899_aabb_ccdd_e7f1;
    logic core_clk, rst, alignChkEn, stValid, retireSt, ldValid;
    logic stReady, ldReady, dcRdEn, dcWrEn, ldRspValid;
    logic [CTRL_W-1:0] ctrlReg0;
    logic [ADDR_W-1:0] dcRdAddr;
    logic [DATA_W-1:0] dcRdData;
    stlf_st_req_t      stReq;
    stlf_ld_req_t      ldReq;
    stlf_dc_wr_t       dcWr;
    stlf_ld_rsp_t      ldRsp, got;
    int                fail_count, n_compared, pend;
    stlf_unit uut (.core_clk, .rst, .ctrlReg0, .alignChkEn, .stValid, .stReq, .stReady, .retireSt, .ldValid,
        .ldReq, .ldReady, .dcRdEn, .dcRdAddr, .dcRdData, .dcWrEn, .dcWr, .ldRspValid, .ldRsp);
    stlf_dcache_model cache (.core_clk, .dcRdEn, .dcRdAddr, .dcWrEn, .dcWr, .dcRdData);
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // ------------------------------
    // shared tasks
    // ------------------------------
    task automatic summarize();
        if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic flag(string m);
        fail_count++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic need(logic c);
        if (c !== 1'b1) begin
            flag("timeout");
            summarize();
        end
    endtask
    task automatic cmpB(logic a, logic e, string m);
        n_compared++;
        if (a !== e) flag(m);
    endtask
    task automatic cmpD(logic [DATA_W-1:0] a, logic [DATA_W-1:0] e, int nb, string m);
        logic [DATA_W-1:0] k;
        k = ~({DATA_W{1'b1}} << (nb * 8));
        n_compared++;
        if ((a & k) !== (e & k)) flag(m);
    endtask
    task automatic store(logic [ADDR_W-1:0] a, stlf_size_t s, logic [DATA_W-1:0] d);
        int i;
        @(negedge core_clk);
        for (i = 0; i < 60 && stReady !== 1'b1; i++) @(negedge core_clk);
        need(i < 60);
        stValid = 1'b1;
        stReq = '{a, s, d};
        @(negedge core_clk);
        stValid = 1'b0;
        pend++;
    endtask
    task automatic issue(logic [ADDR_W-1:0] a, stlf_size_t s);
        int i;
        @(negedge core_clk);
        for (i = 0; i < 60 && ldReady !== 1'b1; i++) @(negedge core_clk);
        need(i < 60);
        ldValid = 1'b1;
        ldReq = '{a, s, 4'h5};
        @(negedge core_clk);
        ldValid = 1'b0;
    endtask
    task automatic waitRsp(int lim, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < lim && !ok; i++) begin
            if (ldRspValid === 1'b1) begin
                ok = 1'b1;
                got = ldRsp;
            end else @(negedge core_clk);
        end
    endtask
    task automatic retireAll();
        int i;
        while (pend > 0) begin
            @(negedge core_clk) retireSt = 1'b1;
            @(negedge core_clk) retireSt = 1'b0;
            for (i = 0; i < 4 && dcWrEn !== 1'b1; i++) @(negedge core_clk);
            cmpB(dcWrEn, 1'b1, "no drain after retire");
            pend--;
        end
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic fwdOk(logic [ADDR_W-1:0] a, stlf_size_t s, int nb, logic [DATA_W-1:0] e);
        logic ok;
        issue(a, s);
        waitRsp(10, ok);
        need(ok);
        cmpB(got.fwd, 1'b1, "not forwarded");
        cmpB(got.tag == 4'h5, 1'b1, "forwarded tag");
        cmpD(got.data, e, nb, "forwarded data");
    endtask
    task automatic refused(logic [ADDR_W-1:0] a, stlf_size_t s, int nb, logic [DATA_W-1:0] e);
        logic ok;
        issue(a, s);
        waitRsp(8, ok);
        cmpB(ok, 1'b0, "answer before drain");
        retireAll();
        waitRsp(40, ok);
        need(ok);
        cmpB(got.fwd, 1'b0, "refused load forwarded");
        cmpB(got.tag == 4'h5, 1'b1, "refused load tag");
        cmpD(got.data, e, nb, "stale load data");
    endtask
    task automatic faultChk(logic [ADDR_W-1:0] a, stlf_size_t s, logic e);
        logic ok;
        issue(a, s);
        waitRsp(20, ok);
        need(ok);
        cmpB(got.alignFault, e, "alignment fault");
    endtask
    initial begin
        {rst, alignChkEn, stValid, retireSt, ldValid, ctrlReg0, stReq, ldReq} = '0;
        rst = 1'b1;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk) rst = 1'b0;
        store(48'h100, SZ_QWORD, D1);
        fwdOk(48'h100, SZ_DWORD, 4, D1);
        fwdOk(48'h100, SZ_QWORD, 8, D1);
        store(48'h200, SZ_DQWORD, D2);
        fwdOk(48'h208, SZ_QWORD, 8, D2 >> 64);
        retireAll();
        store(48'h200, SZ_DQWORD, ~D2);
        refused(48'h204, SZ_DWORD, 4, ~D2 >> 32);
        store(48'h300, SZ_WORD, D1);
        refused(48'h300, SZ_DWORD, 2, D1);
        store(48'h404, SZ_QWORD, D2);
        refused(48'h404, SZ_QWORD, 8, D2);
        store(48'h608, SZ_TBYTE, D1);
        fwdOk(48'h608, SZ_QWORD, 8, D1);
        retireAll();
        store(48'h501, SZ_BYTE, D2);
        store(48'h500, SZ_BYTE, D1);
        refused(48'h500, SZ_BYTE, 1, D1);
        store(48'h600, SZ_BYTE, D1);
        fwdOk(48'h600, SZ_BYTE, 1, D1);
        retireAll();
        faultChk(48'h702, SZ_DWORD, 1'b0);
        ctrlReg0[AM_BIT] = 1'b1;
        alignChkEn = 1'b1;
        faultChk(48'h702, SZ_DWORD, 1'b1);
        faultChk(48'h704, SZ_DWORD, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
